// *** hw/blink_timer.sv ***
// Free-running half-period divider issuing a one-cycle tick.
// Assumes one clock domain and synchronous active-low reset.
`timescale 1ns/1ps
module blink_timer #(
   parameter int unsigned HALF_CYC = lamp_pkg::BLINK_HALF_CYC
) (
   input  wire logic clock,
   input  wire logic rst_n,
   output logic      tick
);
   localparam int unsigned W = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic         next_tick;

   // Refused at elaboration: a one-cycle half period has no count to run
   if (HALF_CYC < 2) begin : g_bad_half
      $error("blink_timer: HALF_CYC must be at least 2");
   end

   always_comb begin
      next_tick  = 1'b0;
      next_count = count + W'(1);
      if (count == W'(HALF_CYC - 1)) begin
         next_count = '0;
         next_tick  = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule

// *** hw/jack_lamps.sv ***
// Lamp driver for a network jack: link/activity lamp and speed lamp.
// Assumes status pins come from outside this clock and are synchronised.
`timescale 1ns/1ps

module jack_lamps #(
   parameter int unsigned HALF_CYC = lamp_pkg::BLINK_HALF_CYC,
   parameter int unsigned HALVES   = lamp_pkg::STRETCH_HALVES
) (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire lamp_pkg::link_status_t status_in,
   output lamp_pkg::lamps_t            lamps
);
   localparam int unsigned SW = $clog2(HALVES + 1) + 1;

   if (HALVES < 2) begin : g_bad_halves
      $error("jack_lamps: HALVES must be at least 2");
   end

   typedef enum logic [0:0] {STEADY, BLINKING} blink_state_t;

   lamp_pkg::link_status_t sync1;
   lamp_pkg::link_status_t sync2;
   logic                   tick;
   blink_state_t           state;
   blink_state_t           next_state;
   logic [SW-1:0]          halves_left;
   logic [SW-1:0]          next_halves_left;
   logic                   phase;
   logic                   next_phase;
   lamp_pkg::lamps_t       next_lamps;

   // Two-stage synchroniser; only sync2 is read by logic
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= status_in;
         sync2 <= sync1;
      end
   end

   blink_timer #(
      .HALF_CYC (HALF_CYC)
   ) u_timer (
      .clock (clock),
      .rst_n (rst_n),
      .tick  (tick)
   );

   // Each traffic pulse refills the stretch, so a short burst still gives
   // at least one full off-on cycle; phase flips on timer ticks while BLINKING and is held at 1 in STEADY.
   always_comb begin
      next_state       = state;
      next_halves_left = halves_left;
      next_phase       = phase;
      case (state)
         STEADY: begin
            next_phase = 1'b1;
            if (sync2.link_up && sync2.activity) begin
               next_state       = BLINKING;
               next_halves_left = SW'(HALVES);
            end
         end
         BLINKING: begin
            if (sync2.activity) begin
               next_halves_left = SW'(HALVES);
            end else if (tick && halves_left != '0) begin
               next_halves_left = halves_left - SW'(1);
            end
            if (tick) begin
               next_phase = ~phase;
            end
            if (!sync2.link_up) begin
               next_state = STEADY;
            end else if (halves_left == '0 && phase && !sync2.activity) begin
               next_state = STEADY;
            end
         end
         default: begin
            next_state = STEADY;
         end
      endcase
   end

   always_comb begin
      next_lamps = '0;
      if (!sync2.link_up) begin
         next_lamps.link_green = lamp_pkg::LAMP_OFF;
      end else if (state == BLINKING) begin
         next_lamps.link_green = phase;
      end else begin
         next_lamps.link_green = lamp_pkg::LAMP_ON;
      end
      case (sync2.speed)
         lamp_pkg::SPEED_100: begin
            next_lamps.speed_green = lamp_pkg::LAMP_ON;
         end
         lamp_pkg::SPEED_1000: begin
            next_lamps.speed_yellow = lamp_pkg::LAMP_ON;
         end
         default: begin
            next_lamps.speed_green  = lamp_pkg::LAMP_OFF;
            next_lamps.speed_yellow = lamp_pkg::LAMP_OFF;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state       <= STEADY;
         halves_left <= '0;
         phase       <= 1'b1;
         lamps       <= '0;
      end else begin
         state       <= next_state;
         halves_left <= next_halves_left;
         phase       <= next_phase;
         lamps       <= next_lamps;
      end
   end

   // Checks
   sequence s_no_link;
      !sync2.link_up;
   endsequence

   property p_dark;
      @(posedge clock) disable iff (!rst_n)
         s_no_link |=> !lamps.link_green;
   endproperty
   a_dark: assert property (p_dark)
      else $error("link lamp lit without link");

   property p_steady;
      @(posedge clock) disable iff (!rst_n)
         (sync2.link_up && state == STEADY) |=> lamps.link_green;
   endproperty
   a_steady: assert property (p_steady)
      else $error("link lamp not steady on idle link");

   property p_blink_start;
      @(posedge clock) disable iff (!rst_n)
         (sync2.link_up && sync2.activity && state == STEADY)
            |=> state == BLINKING;
   endproperty
   a_blink_start: assert property (p_blink_start)
      else $error("traffic did not start blinking");

   property p_blink_follow;
      @(posedge clock) disable iff (!rst_n)
         (sync2.link_up && state == BLINKING)
            |=> lamps.link_green == $past(phase);
   endproperty
   a_blink_follow: assert property (p_blink_follow)
      else $error("link lamp does not follow blink phase");

   property p_speed10;
      @(posedge clock) disable iff (!rst_n)
         (sync2.speed == lamp_pkg::SPEED_10)
            |=> !lamps.speed_green && !lamps.speed_yellow;
   endproperty
   a_speed10: assert property (p_speed10)
      else $error("speed lamp lit at lowest rate");

   property p_speed100;
      @(posedge clock) disable iff (!rst_n)
         (sync2.speed == lamp_pkg::SPEED_100)
            |=> lamps.speed_green && !lamps.speed_yellow;
   endproperty
   a_speed100: assert property (p_speed100)
      else $error("speed lamp not green at middle rate");

   property p_speed1000;
      @(posedge clock) disable iff (!rst_n)
         (sync2.speed == lamp_pkg::SPEED_1000)
            |=> !lamps.speed_green && lamps.speed_yellow;
   endproperty
   a_speed1000: assert property (p_speed1000)
      else $error("speed lamp not yellow at gigabit");

   property p_one_colour;
      @(posedge clock) disable iff (!rst_n)
         !(lamps.speed_green && lamps.speed_yellow);
   endproperty
   a_one_colour: assert property (p_one_colour)
      else $error("both speed colours lit");

   property p_stretch;
      @(posedge clock) disable iff (!rst_n)
         (sync2.activity && sync2.link_up && state == BLINKING)
            |=> halves_left == SW'(HALVES);
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("activity did not refill stretch");

   sequence s_stretching;
      sync2.link_up && state == BLINKING && halves_left != '0;
   endsequence

   property p_stretch_hold;
      @(posedge clock) disable iff (!rst_n)
         s_stretching |=> state == BLINKING;
   endproperty
   a_stretch_hold: assert property (p_stretch_hold)
      else $error("blinking ended before stretch ran out");

   property p_reset_dark;
      @(posedge clock) !rst_n |=> lamps == '0;
   endproperty
   a_reset_dark: assert property (p_reset_dark)
      else $error("lamps lit after reset");

endmodule

// *** include/lamp_pkg.sv ***
// Shared constants and carrier types for the network jack lamp driver.
// Assumes a single 100 MHz clock and status inputs from controller logic.
package lamp_pkg;

   // Clock and blink timing
   localparam int unsigned CLOCK_HZ        = 100_000_000;
   localparam int unsigned BLINK_HALF_MS   = 100;
   localparam int unsigned BLINK_HALF_CYC  =
      (CLOCK_HZ / 1000) * BLINK_HALF_MS;
   localparam int unsigned STRETCH_HALVES  = 2;

   // Speed code encodings
   localparam logic [1:0] SPEED_10   = 2'h0;
   localparam logic [1:0] SPEED_100  = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;

   // Lamp off and on levels
   localparam logic LAMP_OFF = 1'h0;
   localparam logic LAMP_ON  = 1'h1;

   typedef struct packed {
      logic       link_up;
      logic       activity;
      logic [1:0] speed;
   } link_status_t;

   typedef struct packed {
      logic link_green;
      logic speed_green;
      logic speed_yellow;
   } lamps_t;

endpackage

// *** verif/ctrl_status_model.sv ***
// Controller-side status model: link, speed and activity pulses.
// Assumes the bench sets the wanted state; drives at falling edge.
`timescale 1ns/1ps
module ctrl_status_model (
   input  wire logic             clock,
   input  wire logic             want_link,
   input  wire logic [1:0]       want_speed,
   input  wire logic             want_traffic,
   output lamp_pkg::link_status_t status
);
   logic [2:0] beat = 3'h0;
   initial status = '0;
   // Pulses of 4 cycles, long enough to survive the synchroniser
   always @(negedge clock) begin
      beat <= beat + 3'h1;
      status.link_up <= want_link;
      status.speed <= want_speed;
      status.activity <= want_traffic & beat[2];
   end
endmodule

// *** verif/jack_lamps_test.sv ***
// Self-checking bench for the jack lamp driver.
// Assumes a short blink half period so the run stays brief.
`timescale 1ns/1ps
module jack_lamps_test;
   localparam int unsigned HC = 8;
   logic                   clock        = 1'h0;
   logic                   rst_n        = 1'h0;
   logic                   want_link    = 1'h0;
   logic [1:0]             want_speed   = 2'h0;
   logic                   want_traffic = 1'h0;
   lamp_pkg::link_status_t status_in;
   lamp_pkg::lamps_t       lamps;
   int                     n_errors     = 0;
   int                     n_tests      = 0;

   always #5 clock = ~clock;

   ctrl_status_model partner (.clock(clock), .want_link(want_link),
      .want_speed(want_speed), .want_traffic(want_traffic),
      .status(status_in));
   jack_lamps #(.HALF_CYC(HC), .HALVES(2)) dut (.clock(clock),
      .rst_n(rst_n), .status_in(status_in), .lamps(lamps));

   task automatic chk(input string what, input logic [2:0] exp,
                      input logic [2:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic conclude();
      if (n_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Two sync flops and the output flop, with margin
   task automatic settle();
      repeat (6) @(negedge clock);
   endtask

   task automatic no_link();
      want_traffic = 1'h1;
      repeat (5 * HC) begin
         @(negedge clock);
         chk("dark link lamp", 3'h0, {2'h0, lamps.link_green});
      end
      want_traffic = 1'h0;
   endtask

   task automatic speeds();
      logic [1:0] exp [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
      want_link = 1'h1;
      for (int s = 0; s < 4; s++) begin
         want_speed = 2'(s);
         settle();
         chk("speed lamp", {1'h0, exp[s]},
             {1'h0, lamps.speed_green, lamps.speed_yellow});
      end
   endtask

   task automatic steady();
      settle();
      repeat (3 * HC) begin
         @(negedge clock);
         chk("steady link lamp", 3'h1, {2'h0, lamps.link_green});
      end
   endtask

   task automatic traffic();
      int   flips;
      int   run;
      int   shortest;
      logic last;
      flips = 0;
      run = 0;
      shortest = 1000;
      want_traffic = 1'h1;
      settle();
      last = lamps.link_green;
      repeat (8 * HC) begin
         @(negedge clock);
         run++;
         if (lamps.link_green !== last) begin
            if (flips > 0 && run < shortest) shortest = run;
            flips++;
            run = 0;
         end
         last = lamps.link_green;
      end
      chk("blink flips", 3'h1, {2'h0, flips >= 5});
      chk("blink half", 3'h1, {2'h0, shortest >= HC});
      want_traffic = 1'h0;
      // Stretch of two halves plus phase alignment fits in this wait
      repeat (8 * HC) @(negedge clock);
      repeat (3 * HC) begin
         @(negedge clock);
         chk("lamp after stretch", 3'h1, {2'h0, lamps.link_green});
      end
      want_link = 1'h0;
      settle();
      chk("link dropped", 3'h0, {2'h0, lamps.link_green});
   endtask

   // One short pulse must still give a full dark half and end lit
   task automatic burst();
      int dark;
      dark = 0;
      want_link = 1'h1;
      settle();
      want_traffic = 1'h1;
      repeat (8) @(negedge clock);
      want_traffic = 1'h0;
      repeat (8 * HC) begin
         @(negedge clock);
         if (lamps.link_green === 1'h0) dark++;
      end
      chk("burst dark half", 3'h1, {2'h0, dark >= HC});
      chk("burst ends lit", 3'h1, {2'h0, lamps.link_green});
   endtask

   // Mid-run reset: all lamps dark, then status is taken up afresh
   task automatic reset_mid();
      want_speed = 2'h1;
      settle();
      rst_n = 1'h0;
      repeat (2) @(negedge clock);
      chk("lamps in reset", 3'h0, lamps);
      rst_n = 1'h1;
      @(negedge clock);
      chk("lamps at release", 3'h0, lamps);
      settle();
      chk("lamps after reset", 3'h6, lamps);
   endtask

   initial begin
      repeat (4) @(negedge clock);
      rst_n = 1'h1;
      no_link();
      speeds();
      steady();
      traffic();
      burst();
      reset_mid();
      conclude();
   end
endmodule
